// >>> incsp_host.sv
// Host end: serial master that runs one command at a time and queues the replies.
`timescale 1ns/1ns
`default_nettype none
module incsp_host
    import incsp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    incsp_if.host LINK,
    input wire logic I_CMD_VALID,
    input wire logic [CMD_W-1:0] I_CMD,
    output logic O_CMD_READY,
    output logic O_RSP_VALID,
    output logic [15:0] O_RSP_DATA,
    input wire logic I_RSP_READY
);
    typedef enum logic [2:0] {HS_GAP, HS_SETUP, HS_LOW, HS_HIGH, HS_END} incsp_host_e;
    typedef struct packed {
        incsp_host_e st;
        logic [1:0] miso_s;
        logic [15:0] tmr;
        logic [4:0] bit_n;
        logic [4:0] total;
        logic [CMD_W-1:0] cmd;
        logic [18:0] sh_out;
        logic [15:0] rx;
        logic cs_n;
        logic sck;
        logic mosi;
        logic push;
    } incsp_host_s;
    incsp_host_s h_q;
    incsp_host_s h_d;
    logic fifo_ready;
    logic fifo_ovalid;
    logic [15:0] fifo_odata;
    logic rsp_valid_q;
    logic [15:0] rsp_data_q;
    logic take_out;
    function automatic logic [4:0] xfer_bits(input logic [CMD_W-1:0] c);
        case (c)
            READ_TEMP_CMD: xfer_bits = 5'(CMD_W + TMP_W);
            READ_X_ACCEL_CMD, READ_Y_ACCEL_CMD: xfer_bits = 5'(CMD_W + ACC_W);
            default: xfer_bits = 5'(CMD_W);
        endcase
    endfunction : xfer_bits
    assign LINK.chip_sel_n = h_q.cs_n;
    assign LINK.sck = h_q.sck;
    assign LINK.mosi = h_q.mosi;
    assign O_CMD_READY = (h_q.st == HS_GAP) && (h_q.tmr == '0) && fifo_ready;
    assign O_RSP_VALID = rsp_valid_q;
    assign O_RSP_DATA = rsp_data_q;
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        h_d = h_q;
        h_d.push = 1'b0;
        h_d.miso_s = {h_q.miso_s[0], LINK.miso};
        case (h_q.st)
            HS_GAP: begin
                if (h_q.tmr != '0) begin
                    h_d.tmr = h_q.tmr - 16'h0001;
                end else if (I_CMD_VALID && fifo_ready) begin
                    h_d.cs_n = 1'b0;
                    h_d.cmd = I_CMD;
                    h_d.total = xfer_bits(I_CMD);
                    h_d.sh_out = {I_CMD, 11'h000};
                    h_d.bit_n = '0;
                    h_d.rx = '0;
                    h_d.tmr = 16'(SEL_SETUP_CYC);
                    h_d.st = HS_SETUP;
                end
            end
            HS_SETUP: begin
                if (h_q.tmr != '0) begin
                    h_d.tmr = h_q.tmr - 16'h0001;
                end else begin
                    h_d.mosi = h_q.sh_out[18];
                    h_d.sh_out = {h_q.sh_out[17:0], 1'b0};
                    h_d.tmr = 16'(HALF_CYC - 1);
                    h_d.st = HS_LOW;
                end
            end
            HS_LOW: begin
                if (h_q.tmr != '0) begin
                    h_d.tmr = h_q.tmr - 16'h0001;
                end else begin
                    h_d.sck = 1'b1;
                    h_d.tmr = 16'(HALF_CYC - 1);
                    h_d.st = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (h_q.tmr != '0) begin
                    h_d.tmr = h_q.tmr - 16'h0001;
                end else begin
                    h_d.sck = 1'b0;
                    if (h_q.bit_n >= 5'(CMD_W)) begin
                        h_d.rx = {h_q.rx[14:0], h_q.miso_s[1]};
                    end
                    h_d.bit_n = h_q.bit_n + 5'h01;
                    h_d.tmr = 16'(HALF_CYC - 1);
                    if (h_q.bit_n + 5'h01 == h_q.total) begin
                        h_d.st = HS_END;
                    end else begin
                        h_d.mosi = h_q.sh_out[18];
                        h_d.sh_out = {h_q.sh_out[17:0], 1'b0};
                        h_d.st = HS_LOW;
                    end
                end
            end
            HS_END: begin
                if (h_q.tmr != '0) begin
                    h_d.tmr = h_q.tmr - 16'h0001;
                end else begin
                    h_d.cs_n = 1'b1;
                    h_d.push = (h_q.total != 5'(CMD_W));
                    h_d.tmr = 16'(REFRESH_CYC);
                    h_d.st = HS_GAP;
                end
            end
            default: h_d.st = HS_GAP;
        endcase
        if (h_q.st == HS_GAP && h_q.tmr == '0 && I_CMD_VALID && fifo_ready
            && (I_CMD == SELFTEST_X_CMD || I_CMD == SELFTEST_Y_CMD)) begin
            h_d.tmr = 16'(GAP_CYC); // is the caller's duty; the next line replaces this gap with SEL_SETUP_CYC.
            h_d.tmr = 16'(SEL_SETUP_CYC);
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            h_q <= '{st: HS_GAP, miso_s: 2'b11, tmr: 16'(REFRESH_CYC), bit_n: 5'h00,
                     total: 5'h00, cmd: 8'h00, sh_out: 19'h0_0000, rx: 16'h0000,
                     cs_n: 1'b1, sck: 1'b0, mosi: 1'b0, push: 1'b0};
        end else begin
            h_q <= h_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    incsp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .I_CLK(I_CLK),
        .I_RST(I_RST),
        .i_in_valid(h_q.push),
        .o_in_ready(fifo_ready),
        .i_in_data(h_q.rx),
        .o_out_valid(fifo_ovalid),
        .i_out_ready(take_out),
        .o_out_data(fifo_odata)
    );
    assign take_out = fifo_ovalid && (!rsp_valid_q || I_RSP_READY);
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else if (take_out) begin
            rsp_valid_q <= 1'b1;
            rsp_data_q <= fifo_odata;
        end else if (I_RSP_READY) begin
            rsp_valid_q <= 1'b0;
        end
    end
endmodule : incsp_host
`default_nettype wire

// >>> incsp_pkg.sv
// Package with the shared constants of the tilt sensor serial link.
package incsp_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CMD_W = 8;
    localparam int ACC_W = 11;
    localparam int TMP_W = 8;
    localparam logic [7:0] NORMAL_RUN_CMD = 8'h00;
    localparam logic [7:0] READ_TEMP_CMD = 8'h08;
    localparam logic [7:0] SELFTEST_X_CMD = 8'h0E;
    localparam logic [7:0] SELFTEST_Y_CMD = 8'h0F;
    localparam logic [7:0] READ_X_ACCEL_CMD = 8'h10;
    localparam logic [7:0] READ_Y_ACCEL_CMD = 8'h11;
    localparam int REFRESH_US = 150;
    localparam int REFRESH_CYC = REFRESH_US * (CLK_HZ / 1_000_000);
    localparam int GAP_US = 15;
    localparam int GAP_CYC = GAP_US * (CLK_HZ / 1_000_000);
    localparam int SCK_MAX_KHZ = 500;
    localparam int HALF_CYC = (CLK_HZ / (SCK_MAX_KHZ * 1000) + 1) / 2;
    localparam int SEL_SETUP_CYC = 4;
    localparam logic [10:0] ACC_SELFTEST_VAL = 11'h7_FF;
endpackage : incsp_pkg

// >>> incsp_if.sv
// Interface carrying the four serial link wires between host and sensor.
`timescale 1ns/1ns
`default_nettype none
interface incsp_if;
    logic chip_sel_n;
    logic sck;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic miso;
    assign miso = miso_oe_n ? 1'b1 : miso_o;
    modport dev (input chip_sel_n, input sck, input mosi, output miso_o, output miso_oe_n);
    modport host (output chip_sel_n, output sck, output mosi, input miso);
endinterface : incsp_if
`default_nettype wire

// >>> incsp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module incsp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    always_ff @(posedge I_CLK) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : incsp_fifo
`default_nettype wire

// >>> incsp_dev.sv
// Sensor end: serial slave that decodes commands and returns sampled data.
`timescale 1ns/1ns
`default_nettype none
module incsp_dev
    import incsp_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    incsp_if.dev LINK,
    input wire logic [ACC_W-1:0] I_X_SAMPLE,
    input wire logic [ACC_W-1:0] I_Y_SAMPLE,
    input wire logic [TMP_W-1:0] I_TEMP_SAMPLE,
    output logic O_SELFTEST_X,
    output logic O_SELFTEST_Y
);
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_DEAD} incsp_dev_e;
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sck_s;
        logic [1:0] mosi_s;
        logic sck_prev;
        incsp_dev_e st;
        logic [3:0] bits;
        logic [CMD_W-1:0] cmd;
        logic [ACC_W-1:0] shf;
        logic [3:0] out_left;
        logic [ACC_W-1:0] x_reg;
        logic [ACC_W-1:0] y_reg;
        logic [TMP_W-1:0] t_reg;
        logic [15:0] ref_cnt;
        logic selftest_x_cmd;
        logic selftest_y_cmd;
        logic miso;
        logic miso_oe_n;
    } incsp_dev_s;
    incsp_dev_s s_q;
    incsp_dev_s s_d;
    logic cs_n;
    logic sck_rise;
    logic sck_fall;
    logic [CMD_W-1:0] cmd_next;
    // Value loaded into an axis register: an active self test pins it at full scale.
    function automatic logic [ACC_W-1:0] axis_load(input logic st_on,
                                                   input logic [ACC_W-1:0] sample);
        if (st_on) begin
            axis_load = ACC_SELFTEST_VAL;
        end else begin
            axis_load = sample;
        end
    endfunction : axis_load
    // Pin inputs pass two flip-flops before any decoding reads them.
    assign cs_n = s_q.cs_s[1];
    assign sck_rise = s_q.sck_s[1] && !s_q.sck_prev;
    assign sck_fall = !s_q.sck_s[1] && s_q.sck_prev;
    assign cmd_next = {s_q.cmd[CMD_W-2:0], s_q.mosi_s[1]};
    assign LINK.miso_o = s_q.miso;
    assign LINK.miso_oe_n = s_q.miso_oe_n;
    assign O_SELFTEST_X = s_q.selftest_x_cmd;
    assign O_SELFTEST_Y = s_q.selftest_y_cmd;
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.cs_s = {s_q.cs_s[0], LINK.chip_sel_n};
        s_d.sck_s = {s_q.sck_s[0], LINK.sck};
        s_d.mosi_s = {s_q.mosi_s[0], LINK.mosi};
        s_d.sck_prev = s_q.sck_s[1];
        // Data registers refresh only while the link is deselected.
        if (cs_n) begin
            if (s_q.ref_cnt == 16'(REFRESH_CYC - 1)) begin
                s_d.ref_cnt = '0;
                s_d.t_reg = I_TEMP_SAMPLE;
                s_d.x_reg = axis_load(s_q.selftest_x_cmd, I_X_SAMPLE);
                s_d.y_reg = axis_load(s_q.selftest_y_cmd, I_Y_SAMPLE);
            end else begin
                s_d.ref_cnt = s_q.ref_cnt + 16'h0001;
            end
        end
        if (cs_n) begin
            s_d.st = ST_IDLE;
            s_d.bits = '0;
            s_d.cmd = '0;
            s_d.miso_oe_n = 1'b1;
            s_d.miso = 1'b0;
        end else begin
            case (s_q.st)
                ST_IDLE: begin
                    s_d.st = ST_CMD;
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        s_d.cmd = cmd_next;
                        s_d.bits = s_q.bits + 4'h1;
                        // The eighth rising edge completes the command and picks the operation.
                        if (s_q.bits == 4'(CMD_W - 1)) begin
                            s_d.st = ST_DEAD;
                            s_d.out_left = '0;
                            case (cmd_next)
                                NORMAL_RUN_CMD: begin
                                    s_d.selftest_x_cmd = 1'b0;
                                    s_d.selftest_y_cmd = 1'b0;
                                end
                                SELFTEST_X_CMD: s_d.selftest_x_cmd = 1'b1;
                                SELFTEST_Y_CMD: s_d.selftest_y_cmd = 1'b1;
                                READ_TEMP_CMD: begin
                                    s_d.st = ST_DATA;
                                    s_d.shf = {s_q.t_reg, 3'b000};
                                    s_d.out_left = 4'(TMP_W);
                                end
                                READ_X_ACCEL_CMD: begin
                                    s_d.st = ST_DATA;
                                    s_d.shf = s_q.x_reg;
                                    s_d.out_left = 4'(ACC_W);
                                end
                                READ_Y_ACCEL_CMD: begin
                                    s_d.st = ST_DATA;
                                    s_d.shf = s_q.y_reg;
                                    s_d.out_left = 4'(ACC_W);
                                end
                                default: s_d.st = ST_DEAD;
                            endcase
                        end
                    end
                end
                ST_DATA: begin
                    // Input bits arriving now are ignored; output shifts out.
                    if (sck_fall) begin
                        if (s_q.out_left != '0) begin
                            s_d.miso = s_q.shf[ACC_W-1];
                            s_d.shf = {s_q.shf[ACC_W-2:0], 1'b0};
                            s_d.out_left = s_q.out_left - 4'h1;
                            s_d.miso_oe_n = 1'b0;
                        end
                        // The last reply bit stands until the select rises, so a host that
                        // samples late in the final clock still sees it.
                    end
                end
                ST_DEAD: begin
                    s_d.miso_oe_n = 1'b1;
                end
                default: s_d.st = ST_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Reset leaves the link idle, the output released and the self tests off.
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            s_q <= '{cs_s: 2'b11,
                     sck_s: 2'b00,
                     mosi_s: 2'b00,
                     sck_prev: 1'b0,
                     st: ST_IDLE,
                     bits: 4'h0,
                     cmd: 8'h00,
                     shf: 11'h000,
                     out_left: 4'h0,
                     x_reg: 11'h400,
                     y_reg: 11'h400,
                     t_reg: 8'h00,
                     ref_cnt: 16'h0000,
                     selftest_x_cmd: 1'b0,
                     selftest_y_cmd: 1'b0,
                     miso: 1'b0,
                     miso_oe_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end
endmodule : incsp_dev
`default_nettype wire

// >>> incsp_link_asserts.sv
// Checker that watches the serial link wires between the host and sensor ends.
`timescale 1ns/1ns
`default_nettype none
module incsp_link_asserts
    import incsp_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic chip_sel_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    logic sck_p_q;
    logic [4:0] cnt_q;
    logic [7:0] cmd_q;
    logic [7:0] fall_age_q;
    logic [7:0] sck_age_q;
    logic [11:0] hi_age_q;
    logic rd;
    assign rd = (cmd_q == READ_TEMP_CMD) || (cmd_q == READ_X_ACCEL_CMD)
        || (cmd_q == READ_Y_ACCEL_CMD);
    ////////////////////////////////////////////////////////////////////////////////
    // Bits clocked in this frame, the command, and ages of the last clock edges.
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sck_p_q <= 1'b0;
            cnt_q <= 5'h00;
            cmd_q <= 8'h00;
            fall_age_q <= 8'hFF;
            sck_age_q <= 8'hFF;
            hi_age_q <= 12'h000;
        end else begin
            sck_p_q <= sck;
            sck_age_q <= (sck != sck_p_q) ? 8'h00 : sck_age_q + {7'h00, sck_age_q != 8'hFF};
            fall_age_q <= (sck_p_q && !sck) ? 8'h00 : fall_age_q + {7'h00, fall_age_q != 8'hFF};
            hi_age_q <= !chip_sel_n ? 12'h000 : hi_age_q + {11'h000, hi_age_q != 12'hFFF};
            if (chip_sel_n) begin
                cnt_q <= 5'h00;
            end else if (sck && !sck_p_q) begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q < 5'h08) begin
                    cmd_q <= {cmd_q[6:0], mosi};
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    sequence s_sel_idle;
        chip_sel_n [*5];
    endsequence
    sequence s_first_drive;
        $fell(miso_oe_n);
    endsequence
    sequence s_bit_edge;
        !chip_sel_n && $changed(sck);
    endsequence
    AST_IDLE_RELEASED: assert property (s_sel_idle |-> miso_oe_n)
        else $error("data line driven while deselected");
    AST_SCK_STILL: assert property (chip_sel_n |-> !sck)
        else $error("serial clock high outside a frame");
    AST_SCK_HALF: assert property (s_bit_edge |-> sck_age_q >= 8'h13)
        else $error("serial clock phase shorter than one microsecond");
    AST_CS_GAP: assert property ($fell(chip_sel_n) |-> hi_age_q >= REFRESH_CYC - 1)
        else $error("select gap too short");
    AST_FIRST_BIT: assert property (s_first_drive |-> cnt_q == 5'h08 && fall_age_q <= 8'h06)
        else $error("first reply bit not at the fall after the command");
    AST_MISO_ON_FALL: assert property (!miso_oe_n && !$past(miso_oe_n) && $changed(miso_o)
        |-> fall_age_q <= 8'h06)
        else $error("reply bit changed away from a falling clock edge");
    AST_BAD_QUIET: assert property (!chip_sel_n && cnt_q >= 5'h08 && !rd |-> miso_oe_n)
        else $error("data line driven after a command without reply");
    AST_READ_DRIVES: assert property (!chip_sel_n && rd && cnt_q >= 5'h09 |-> !miso_oe_n)
        else $error("data line released during a read");
    AST_FRAME_LEN: assert property ($rose(chip_sel_n) && rd
        |-> cnt_q == ((cmd_q == READ_TEMP_CMD) ? 5'h10 : 5'h13))
        else $error("read frame has wrong bit count");
endmodule : incsp_link_asserts
`default_nettype wire

// >>> inclinometer_spi_slave_tb.sv
// Self-checking bench joining the host and sensor ends over the serial link.
`timescale 1ns/1ns
`default_nettype none
module inclinometer_spi_slave_tb
    import incsp_pkg::*;
;
    typedef struct packed {
        logic [7:0] cmd;
        logic rd;
        logic [15:0] exp;
        logic selftest_x_cmd;
        logic selftest_y_cmd;
    } incsp_row_s;
    localparam int LIMIT = 90000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic rsp_ready = 1'b1;
    logic [7:0] temp = 8'h9B;
    logic cmd_ready, rsp_valid, st_x, st_y, sck_p;
    logic [15:0] rsp_data;
    logic [7:0] wire_cmd;
    logic [15:0] wire_rsp;
    int wcnt = 0;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    incsp_row_s rows [12];
    incsp_if link ();
    incsp_dev u_incsp_dev (.I_CLK(clk), .I_RST(rst), .LINK(link.dev), .I_X_SAMPLE(11'h5A3),
        .I_Y_SAMPLE(11'h2C6), .I_TEMP_SAMPLE(temp), .O_SELFTEST_X(st_x), .O_SELFTEST_Y(st_y));
    incsp_host #(.FIFO_DEPTH(2)) u_incsp_host (.I_CLK(clk), .I_RST(rst), .LINK(link.host),
        .I_CMD_VALID(cmd_valid), .I_CMD(cmd), .O_CMD_READY(cmd_ready), .O_RSP_VALID(rsp_valid),
        .O_RSP_DATA(rsp_data), .I_RSP_READY(rsp_ready));
    incsp_link_asserts u_incsp_link_asserts (.I_CLK(clk), .I_RST(rst),
        .chip_sel_n(link.chip_sel_n), .sck(link.sck), .mosi(link.mosi), .miso_o(link.miso_o),
        .miso_oe_n(link.miso_oe_n));
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    // Rebuilds the command and the reply from the wire itself.
    always @(posedge clk) begin
        sck_p <= link.sck;
        if (link.chip_sel_n) begin
            wcnt <= 0;
        end else if (link.sck && !sck_p) begin
            wcnt <= wcnt + 1;
            if (wcnt < 8) begin
                wire_cmd <= {wire_cmd[6:0], link.mosi};
            end
        end else if (!link.sck && sck_p && wcnt >= 9) begin
            wire_rsp <= {wire_rsp[14:0], link.miso};
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] c);
        int k;
        k = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && k < 8000) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : send
    task automatic frame();
        int k;
        k = 0;
        while (link.chip_sel_n !== 1'b0 && k < 8000) begin
            @(negedge clk);
            k++;
        end
        while (link.chip_sel_n !== 1'b1 && k < 8000) begin
            @(negedge clk);
            k++;
        end
    endtask : frame
    task automatic get(input logic [15:0] exp);
        int k;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        chk((rsp_valid === 1'b1) ? rsp_data : 16'hDEAD, exp);
        @(negedge clk);
    endtask : get
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{NORMAL_RUN_CMD, 1'b0, 16'h0000, 1'b0, 1'b0},
            '{READ_X_ACCEL_CMD, 1'b1, 16'h05A3, 1'b0, 1'b0},
            '{READ_Y_ACCEL_CMD, 1'b1, 16'h02C6, 1'b0, 1'b0},
            '{READ_TEMP_CMD, 1'b1, 16'h009B, 1'b0, 1'b0},
            '{SELFTEST_X_CMD, 1'b0, 16'h0000, 1'b1, 1'b0},
            '{READ_X_ACCEL_CMD, 1'b1, 16'h07FF, 1'b0, 1'b0},
            '{READ_Y_ACCEL_CMD, 1'b1, 16'h02C6, 1'b0, 1'b0},
            '{NORMAL_RUN_CMD, 1'b0, 16'h0000, 1'b0, 1'b0},
            '{READ_X_ACCEL_CMD, 1'b1, 16'h05A3, 1'b0, 1'b0},
            '{SELFTEST_Y_CMD, 1'b0, 16'h0000, 1'b0, 1'b1},
            '{READ_Y_ACCEL_CMD, 1'b1, 16'h07FF, 1'b0, 1'b0},
            '{NORMAL_RUN_CMD, 1'b0, 16'h0000, 1'b0, 1'b0}};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({14'h0000, st_x, st_y}, 16'h0000);
        chk({15'h0000, link.miso}, 16'h0001);
        foreach (rows[i]) begin
            send(rows[i].cmd);
            frame();
            chk({8'h00, wire_cmd}, {8'h00, rows[i].cmd});
            if (rows[i].rd) begin
                get(rows[i].exp);
                chk(wire_rsp & ((rows[i].cmd == READ_TEMP_CMD) ? 16'h00FF : 16'h07FF),
                    rows[i].exp);
            end else begin
                repeat (8) @(negedge clk);
                chk({14'h0000, st_x, st_y}, {14'h0000, rows[i].selftest_x_cmd, rows[i].selftest_y_cmd});
            end
        end
        send(8'h55);
        frame();
        repeat (100) @(negedge clk);
        chk({15'h0000, rsp_valid}, 16'h0000);
        send(READ_TEMP_CMD);
        while (link.chip_sel_n !== 1'b0) begin
            @(negedge clk);
        end
        repeat (8) @(posedge clk);
        temp <= 8'h3C;
        frame();
        get(16'h009B);
        @(posedge clk);
        rsp_ready <= 1'b0;
        repeat (3) begin
            send(READ_TEMP_CMD);
            frame();
        end
        repeat (3100) @(negedge clk);
        chk({15'h0000, cmd_ready}, 16'h0000);
        @(posedge clk);
        rsp_ready <= 1'b1;
        @(negedge clk);
        repeat (3) get(16'h003C);
        repeat (4) @(negedge clk);
        chk({14'h0000, rsp_valid, cmd_ready}, 16'h0001);
        test_done();
    end
endmodule : inclinometer_spi_slave_tb
`default_nettype wire
